// file: design/mac_pkg.sv
// Constants and carrier types for the multiply-accumulate unit
// Overview of operation
// RULE1: Write E9h loads the Y operand
// RULE2: Read EAh returns product high byte
// RULE3: Read EBh returns product low byte
// RULE4: Read ECh returns accumulator bits 15:8
// RULE5: Write ECh loads X and accumulates
// RULE6: Read EDh returns accumulator bits 7:0
// RULE7: Write EDh loads Y and accumulates
// RULE8: Read EEh returns accumulator bits 31:24
// RULE9: Read EFh returns accumulator bits 23:16
// RULE10: Any write to EEh or EFh clears accumulator
// RULE11: Signed 8-bit operands, 16-bit product, 32-bit accumulator
// RULE12: Plain operand writes never touch the accumulator
// RULE13: X and Y shared by both functions
// RULE14: Processor waits one instruction before upper bytes
// RULE15: Accumulate wraps modulo two to thirty-two
// RULE16: Reset clears operands, product and accumulator
package mac_pkg;
	localparam int OPER_W = 8;
	localparam int PROD_W = 16;
	localparam int ACC_W = 32;
	localparam int BYTE_W = 8;
	localparam int IDX_BYTE0 = 0;
	localparam int IDX_BYTE1 = 1;
	localparam int IDX_BYTE2 = 2;
	localparam int IDX_BYTE3 = 3;
	localparam logic MAC_BANK = 1'b0;
	localparam logic [7:0] OFF_PRODUCT_X = 8'he8;
	localparam logic [7:0] OFF_PRODUCT_Y = 8'he9;
	localparam logic [7:0] OFF_PROD_HIGH = 8'hea;
	localparam logic [7:0] OFF_PROD_LOW = 8'heb;
	localparam logic [7:0] OFF_ACC1_MACX = 8'hec;
	localparam logic [7:0] OFF_ACC0_MACY = 8'hed;
	localparam logic [7:0] OFF_ACC3_CLRA = 8'hee;
	localparam logic [7:0] OFF_ACC2_CLRB = 8'hef;
	localparam logic [7:0] OPER_RESET = 8'h00;
	localparam logic [15:0] PROD_RESET = 16'h0000;
	localparam logic [31:0] ACC_RESET = 32'h0000_0000;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// One access of the processor's internal register bus
	typedef struct packed {
		logic bank;
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} mac_req_t;

	// Whole state of the unit
	typedef struct packed {
		logic [7:0] oper_x;
		logic [7:0] oper_y;
		logic [15:0] product;
		logic [31:0] accum;
		logic [7:0] rdata;
	} mac_state_t;
endpackage

// file: design/mac_mult.sv
// Signed 8 by 8 multiplier
`timescale 1ns/100ps
module mac_mult
	import mac_pkg::*;
(
	// Operands
	input wire logic [OPER_W-1:0] op_a,
	input wire logic [OPER_W-1:0] op_b,
	// Result
	output logic [PROD_W-1:0] product
);
	always_comb
	begin
		product = PROD_W'($signed(op_a) * $signed(op_b)); // RULE11
	end
endmodule

// file: design/mac_unit.sv
// Memory-mapped signed multiplier and multiply-accumulator
`timescale 1ns/100ps
module mac_unit
	import mac_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Register bus request
	input wire mac_req_t req,
	// Register bus read data
	output logic [7:0] rdata
);
	mac_state_t st_r;
	mac_state_t st_nxt;
	logic [PROD_W-1:0] prod_nxt;
	logic [OPER_W-1:0] multiply_operand_x;
	logic [OPER_W-1:0] multiply_operand_y;
	logic [BYTE_W-1:0] acc_byte [ACC_W/BYTE_W];
	logic [BYTE_W-1:0] prod_byte [PROD_W/BYTE_W];

	function automatic logic hit(input mac_req_t r, input logic [7:0] off);
		hit = (r.bank == MAC_BANK) && (r.addr == off);
	endfunction

	logic wr_x_plain;
	logic wr_y_plain;
	logic wr_x_mac;
	logic wr_y_mac;
	logic wr_clear;

	assign wr_x_plain = req.wr && hit(req, OFF_PRODUCT_X);
	assign wr_y_plain = req.wr && hit(req, OFF_PRODUCT_Y);
	assign wr_x_mac = req.wr && hit(req, OFF_ACC1_MACX);
	assign wr_y_mac = req.wr && hit(req, OFF_ACC0_MACY);
	assign wr_clear = req.wr && (hit(req, OFF_ACC3_CLRA) || hit(req, OFF_ACC2_CLRB));

	// Multiplier sees the operand being written, so an accumulate uses the fresh value
	assign multiply_operand_x = (wr_x_plain || wr_x_mac) ? req.wdata : st_r.oper_x; // RULE13
	assign multiply_operand_y = (wr_y_plain || wr_y_mac) ? req.wdata : st_r.oper_y; // RULE13

	mac_mult mac_mult_inst
	(
		.op_a(multiply_operand_x),
		.op_b(multiply_operand_y),
		.product(prod_nxt)
	);

	// Byte views of the result registers for the read path
	for (genvar i = 0; i < ACC_W/BYTE_W; i++)
	begin : g_acc_byte
		assign acc_byte[i] = st_r.accum[i*BYTE_W +: BYTE_W];
	end
	for (genvar i = 0; i < PROD_W/BYTE_W; i++)
	begin : g_prod_byte
		assign prod_byte[i] = st_r.product[i*BYTE_W +: BYTE_W];
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.oper_x = multiply_operand_x; // RULE5
		st_nxt.oper_y = multiply_operand_y; // RULE1 RULE7
		st_nxt.product = prod_nxt; // RULE11
		if (wr_x_mac || wr_y_mac)
		begin
			// Plain wrap, no saturation: software sees the raw modulo sum
			st_nxt.accum = st_r.accum + {{(ACC_W-PROD_W){prod_nxt[PROD_W-1]}}, prod_nxt}; // RULE12 RULE15
		end
		else if (wr_clear)
		begin
			st_nxt.accum = ACC_RESET; // RULE10
		end
		if (req.rd)
		begin
			// Unmapped and write-only addresses read as zero
			st_nxt.rdata = RDATA_IDLE;
			if (req.bank == MAC_BANK)
			begin
				case (req.addr)
					OFF_PROD_HIGH:
					begin
						st_nxt.rdata = prod_byte[IDX_BYTE1]; // RULE2
					end
					OFF_PROD_LOW:
					begin
						st_nxt.rdata = prod_byte[IDX_BYTE0]; // RULE3
					end
					OFF_ACC1_MACX:
					begin
						st_nxt.rdata = acc_byte[IDX_BYTE1]; // RULE4
					end
					OFF_ACC0_MACY:
					begin
						st_nxt.rdata = acc_byte[IDX_BYTE0]; // RULE6
					end
					OFF_ACC3_CLRA:
					begin
						st_nxt.rdata = acc_byte[IDX_BYTE3]; // RULE8
					end
					OFF_ACC2_CLRB:
					begin
						st_nxt.rdata = acc_byte[IDX_BYTE2]; // RULE9
					end
					default:
					begin
						st_nxt.rdata = RDATA_IDLE;
					end
				endcase
			end
		end
	end

	// Accumulate completes in one edge, so the processor spacing is met with margin
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			st_r <= '{OPER_RESET, OPER_RESET, PROD_RESET, ACC_RESET, RDATA_IDLE}; // RULE16
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;

	logic signed [31:0] mac_inc_x;
	logic signed [31:0] mac_inc_y;
	assign mac_inc_x = 32'($signed(req.wdata) * $signed(st_r.oper_y));
	assign mac_inc_y = 32'($signed(st_r.oper_x) * $signed(req.wdata));

	y_load_a: assert property (@(posedge clock) disable iff (reset) // RULE1
		wr_y_plain |=> st_r.oper_y == $past(req.wdata))
		else $error("Y operand not loaded");

	prod_high_a: assert property (@(posedge clock) disable iff (reset) // RULE2
		req.rd && hit(req, OFF_PROD_HIGH) |=> rdata == $past(prod_byte[IDX_BYTE1]))
		else $error("Product high byte wrong");

	prod_low_a: assert property (@(posedge clock) disable iff (reset) // RULE3
		req.rd && hit(req, OFF_PROD_LOW) |=> rdata == $past(prod_byte[IDX_BYTE0]))
		else $error("Product low byte wrong");

	acc_byte1_a: assert property (@(posedge clock) disable iff (reset) // RULE4
		req.rd && hit(req, OFF_ACC1_MACX) |=> rdata == $past(acc_byte[IDX_BYTE1]))
		else $error("Accumulator byte 1 wrong");

	accumulate_operand_x_a: assert property (@(posedge clock) disable iff (reset) // RULE5
		wr_x_mac |=> st_r.oper_x == $past(req.wdata) && st_r.accum == $past(st_r.accum) + $past(mac_inc_x))
		else $error("Accumulate on X wrong");

	acc_byte0_a: assert property (@(posedge clock) disable iff (reset) // RULE6
		req.rd && hit(req, OFF_ACC0_MACY) |=> rdata == $past(acc_byte[IDX_BYTE0]))
		else $error("Accumulator byte 0 wrong");

	accumulate_operand_y_a: assert property (@(posedge clock) disable iff (reset) // RULE7
		wr_y_mac |=> st_r.oper_y == $past(req.wdata) && st_r.accum == $past(st_r.accum) + $past(mac_inc_y))
		else $error("Accumulate on Y wrong");

	acc_byte3_a: assert property (@(posedge clock) disable iff (reset) // RULE8
		req.rd && hit(req, OFF_ACC3_CLRA) |=> rdata == $past(acc_byte[IDX_BYTE3]))
		else $error("Accumulator byte 3 wrong");

	acc_byte2_a: assert property (@(posedge clock) disable iff (reset) // RULE9
		req.rd && hit(req, OFF_ACC2_CLRB) |=> rdata == $past(acc_byte[IDX_BYTE2]))
		else $error("Accumulator byte 2 wrong");

	acc_clear_a: assert property (@(posedge clock) disable iff (reset) // RULE10
		wr_clear |=> st_r.accum == ACC_RESET)
		else $error("Accumulator not cleared");

	// A request for the other bank must leave every operand and the sum alone
	bank_refuse_a: assert property (@(posedge clock) disable iff (reset) // RULE10
		req.bank != MAC_BANK |=> st_r.oper_x == $past(st_r.oper_x) && st_r.oper_y == $past(st_r.oper_y)
			&& $stable(st_r.accum))
		else $error("Other bank changed state");

	prod_value_a: assert property (@(posedge clock) disable iff (reset) // RULE11
		st_r.product == PROD_W'($signed(st_r.oper_x) * $signed(st_r.oper_y)))
		else $error("Product mismatch");

	plain_keep_a: assert property (@(posedge clock) disable iff (reset) // RULE12
		wr_x_plain || wr_y_plain |=> $stable(st_r.accum))
		else $error("Plain write changed accumulator");

	acc_keep_a: assert property (@(posedge clock) disable iff (reset) // RULE12
		!(wr_x_mac || wr_y_mac || wr_clear) |=> $stable(st_r.accum))
		else $error("Accumulator moved without a trigger");

	shared_x_a: assert property (@(posedge clock) disable iff (reset) // RULE13
		wr_x_plain |=> st_r.oper_x == $past(req.wdata)
			&& st_r.product == PROD_W'($signed($past(req.wdata)) * $signed(st_r.oper_y)))
		else $error("X not shared");

	shared_y_a: assert property (@(posedge clock) disable iff (reset) // RULE13
		wr_y_mac |=> st_r.product == PROD_W'($signed(st_r.oper_x) * $signed($past(req.wdata))))
		else $error("Y not shared");

	// Write-only and unmapped slots must not leak stale result bytes
	idle_read_a: assert property (@(posedge clock) disable iff (reset) // RULE1
		req.rd && !(req.bank == MAC_BANK && req.addr >= OFF_PROD_HIGH && req.addr <= OFF_ACC2_CLRB)
			|=> rdata == RDATA_IDLE)
		else $error("Idle read not zero");

	rdata_hold_a: assert property (@(posedge clock) disable iff (reset) // RULE2
		!req.rd |=> $stable(rdata))
		else $error("Read data changed without a read");

	reset_zero_a: assert property (@(posedge clock) // RULE16
		$fell(reset) |-> st_r.accum == ACC_RESET && st_r.oper_x == OPER_RESET && st_r.oper_y == OPER_RESET
			&& st_r.product == PROD_RESET && rdata == RDATA_IDLE)
		else $error("State not cleared at reset");

	mac_run_c: cover property (@(posedge clock) disable iff (reset) wr_x_mac ##[2:4] wr_y_mac);
	clear_c: cover property (@(posedge clock) disable iff (reset) wr_clear ##[1:8] (wr_x_mac || wr_y_mac));
	wrap_c: cover property (@(posedge clock) disable iff (reset)
		(wr_x_mac || wr_y_mac) ##1 st_r.accum[ACC_W-1] != $past(st_r.accum[ACC_W-1]));
	refuse_c: cover property (@(posedge clock) disable iff (reset) req.wr && req.bank != MAC_BANK);
	upper_read_c: cover property (@(posedge clock) disable iff (reset) wr_y_mac ##3 (req.rd && hit(req, OFF_ACC3_CLRA)));
endmodule

// file: verif/mac_cpu_model.sv
// Processor core model issuing register bus cycles
`timescale 1ns/100ps
module mac_cpu_model
	import mac_pkg::*;
(
	// Clock
	input wire logic clock,
	// Register bus
	output mac_req_t req,
	input wire logic [7:0] rdata
);
	initial req = '{bank: 1'b0, addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
	task automatic access(input logic bank, input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] data);
		@(posedge clock);
		#1;
		req = '{bank: bank, addr: addr, wr: wr, rd: !wr, wdata: wdata};
		@(posedge clock);
		#1;
		data = rdata;
		// Released lines must not keep showing the old value
		req = '{bank: bank, addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~wdata};
		// Spare instruction after an accumulate write, as the core is obliged to give
		if (wr && (addr == OFF_ACC1_MACX || addr == OFF_ACC0_MACY))
			@(posedge clock);
	endtask
endmodule

// file: verif/tb_multiply_accumulate_unit.sv
// Self-checking bench for the multiply-accumulate unit
`timescale 1ns/100ps
module tb_multiply_accumulate_unit
	import mac_pkg::*;
;
	logic clock = 1'b0;
	logic reset = 1'b1;
	mac_req_t req;
	logic [7:0] rdata;
	logic [7:0] seen;
	int errors = 0;
	int check_count = 0;
	// Rows are {write, offset, write data or expected read}
	logic [16:0] rows [26] = '{17'h1e805, 17'h1e9fd, 17'h0eaff, 17'h0ebf1, 17'h0ed00, 17'h1ec05, 17'h0edf1,
		17'h0ecff, 17'h0eeff, 17'h0efff, 17'h1ed80, 17'h0eafd, 17'h0eb80, 17'h0ed71, 17'h0ecfd, 17'h1ee5a,
		17'h0ee00, 17'h0ed00, 17'h1ec80, 17'h0ec40, 17'h1ef00, 17'h0ec00, 17'h1e7ff, 17'h0e700, 17'h0e800,
		17'h0e900};

	always #4 clock = ~clock;

	mac_unit mac_unit_inst (.clock(clock), .reset(reset), .req(req), .rdata(rdata));
	mac_cpu_model mac_cpu_model_inst (.clock(clock), .req(req), .rdata(rdata));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge clock);
		#1;
		reset = 1'b0;
		foreach (rows[i])
		begin
			mac_cpu_model_inst.access(1'b0, rows[i][16], rows[i][15:8], rows[i][7:0], seen);
			if (!rows[i][16])
				check(seen, rows[i][7:0]);
		end
		// Other bank is ignored for writes and reads back zero
		mac_cpu_model_inst.access(1'b0, 1'b1, OFF_ACC1_MACX, 8'h01, seen);
		mac_cpu_model_inst.access(1'b1, 1'b1, OFF_ACC3_CLRA, 8'h00, seen);
		mac_cpu_model_inst.access(1'b1, 1'b0, OFF_ACC0_MACY, 8'h00, seen);
		check(seen, 8'h00);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_ACC3_CLRA, 8'h00, seen);
		check(seen, 8'hff);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_ACC0_MACY, 8'h00, seen);
		check(seen, 8'h80);
		// Carry out of bit 31 is dropped, so the negative sum comes back positive
		mac_cpu_model_inst.access(1'b0, 1'b1, OFF_ACC1_MACX, 8'h80, seen);
		mac_cpu_model_inst.access(1'b0, 1'b1, OFF_ACC0_MACY, 8'h01, seen);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_ACC3_CLRA, 8'h00, seen);
		check(seen, 8'h00);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_ACC2_CLRB, 8'h00, seen);
		check(seen, 8'h00);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_ACC1_MACX, 8'h00, seen);
		check(seen, 8'h3f);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_ACC0_MACY, 8'h00, seen);
		check(seen, 8'h00);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_PROD_HIGH, 8'h00, seen);
		check(seen, 8'hff);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_PROD_LOW, 8'h00, seen);
		check(seen, 8'h80);
		// Reset in mid-run with live state
		@(posedge clock);
		#1;
		reset = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		reset = 1'b0;
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_ACC1_MACX, 8'h00, seen);
		check(seen, ACC_RESET[15:8]);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_PROD_HIGH, 8'h00, seen);
		check(seen, PROD_RESET[15:8]);
		mac_cpu_model_inst.access(1'b0, 1'b0, OFF_PROD_LOW, 8'h00, seen);
		check(seen, PROD_RESET[7:0]);
		complete_run();
	end

	// Test needs about 113 cycles; this is far beyond
	initial
	begin
		#100000;
		errors++;
		complete_run();
	end
endmodule
